// ==== logic/fetch_defines.svh ====
// Constants for the instruction fetch pipeline: widths, addresses, opcode patterns
`ifndef FETCH_DEFINES_SVH
`define FETCH_DEFINES_SVH

`define PC_W             21
`define WORD_W           16
`define DADDR_W          12
`define PC_RESET         21'h000000
`define PC_STEP          21'h000002
`define BYTE_ZERO        8'h00
`define WORD_NOP         16'h0000
`define PHASE_HOT_ONE    4'h1
`define PHASE_HOT_TWO    4'h2
`define PHASE_HOT_THREE  4'h4
`define PHASE_HOT_FOUR   4'h8

`define SECOND_TAG       4'hF
`define OPC_GOTO         8'hEF
`define OPC_CALL         7'h76
`define OPC_LFSR         8'hEE
`define OPC_MOVE         4'hC
`define OPC_BRA          5'h1A
`define OPC_TEST_FILE_SKIP_IF_ZERO       7'h33
`define OPC_ADD_W_TO_FILE        6'h09
`define OPC_RETURN_WITH_LITERAL        8'h0C
`define OPC_MOVLW        8'h0E
`define OPC_TBLRD        14'h0002

`define ADDR_PC_LOW      12'hFF9
`define ADDR_TBL_LATCH   12'hFF5
`define ADDR_TBL_LOW     12'hFF6
`define ADDR_TBL_HIGH    12'hFF7
`define ADDR_TBL_UPPER   12'hFF8
`define ACCESS_SPLIT     8'h60
`define ACCESS_HIGH_BANK 4'hF
`define ACCESS_LOW_BANK  4'h0

`endif

// ==== logic/fetch_pkg.sv ====
// Types shared by the instruction fetch pipeline
package fetch_pkg;
    typedef enum logic [1:0] {phase_one, phase_two, phase_three, phase_four} phase_type;
    typedef enum logic [3:0] {
        op_nop, op_goto, op_call, op_lfsr, op_move, op_second, op_bra,
        op_test_file_skip_if_zero, op_add_w_to_file, op_return_with_literal, op_movlw, op_tblrd
    } op_type;
endpackage

// ==== logic/instruction_fetch_pipeline.sv ====
// Four-phase fetch and execute pipeline of the 8-bit core
`timescale 1ns/1ps
`include "fetch_defines.svh"

module instruction_fetch_pipeline (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    output logic [3:0]                 phase_clk,
    output logic [`PC_W-1:0]           pc,
    output logic [`PC_W-1:0]           prog_addr,
    output logic                       prog_rd,
    input  wire logic [`WORD_W-1:0]    prog_data,
    output logic [`DADDR_W-1:0]        data_addr,
    output logic                       data_rd,
    input  wire logic [7:0]            data_rdata,
    output logic                       data_wr,
    output logic [7:0]                 data_wdata,
    input  wire logic [3:0]            bank_select,
    output logic                       stack_push,
    output logic [`PC_W-1:0]           push_addr,
    output logic                       stack_pop,
    input  wire logic [`PC_W-1:0]      return_addr,
    output logic                       fsr_load,
    output logic [1:0]                 fsr_index,
    output logic [11:0]                fsr_value,
    output logic [`WORD_W-1:0]         instruction_latch,
    output logic                       exec_valid,
    output logic [7:0]                 working_register,
    output logic [`PC_W-1:0]           table_pointer,
    output logic [7:0]                 table_latch
);

    fetch_pkg::phase_type  phase;
    fetch_pkg::op_type     op;
    fetch_pkg::op_type     pending;
    logic [7:0]            pending_low;
    logic [`PC_W-1:0]      fetch_addr;
    logic [7:0]            operand;
    logic [7:0]            move_byte;
    logic                  branch_taken;
    logic [`PC_W-1:0]      branch_target;
    logic                  skip_next;
    logic                  w_load;
    logic [7:0]            w_value;
    logic [`DADDR_W-1:0]   ex_file;
    logic [7:0]            sum;
    logic                  next_wr;
    logic [`DADDR_W-1:0]   next_waddr;
    logic [7:0]            next_wdata;
    logic                  next_branch;
    logic [`PC_W-1:0]      next_target;

    function automatic logic [`DADDR_W-1:0] file_addr(input logic a, input logic [7:0] f,
                                                     input logic [3:0] bsr);
        if (a) begin
            return {bsr, f};
        end else if (f >= `ACCESS_SPLIT) begin
            return {`ACCESS_HIGH_BANK, f};
        end else begin
            return {`ACCESS_LOW_BANK, f};
        end
    endfunction

    // Phase sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase     <= fetch_pkg::phase_one;
            phase_clk <= `PHASE_HOT_ONE;
        end else if (clk_en) begin
            case (phase)
                fetch_pkg::phase_one:   phase <= fetch_pkg::phase_two;
                fetch_pkg::phase_two:   phase <= fetch_pkg::phase_three;
                fetch_pkg::phase_three: phase <= fetch_pkg::phase_four;
                default:                phase <= fetch_pkg::phase_one;
            endcase
            // One-hot copy walks in step with the state
            phase_clk <= {phase_clk[2:0], phase_clk[3]};
        end
    end

    // Decode of the word in the latch
    always_comb begin
        op = fetch_pkg::op_nop;
        if (!exec_valid) begin
            op = fetch_pkg::op_nop;
        end else if (instruction_latch[15:8] == `OPC_GOTO) begin
            op = fetch_pkg::op_goto;
        end else if (instruction_latch[15:9] == `OPC_CALL) begin
            op = fetch_pkg::op_call;
        end else if (instruction_latch[15:8] == `OPC_LFSR) begin
            op = fetch_pkg::op_lfsr;
        end else if (instruction_latch[15:12] == `OPC_MOVE) begin
            op = fetch_pkg::op_move;
        end else if (instruction_latch[15:12] == `SECOND_TAG) begin
            // Lone second words fall through as no-operation
            op = (pending != fetch_pkg::op_nop) ? fetch_pkg::op_second : fetch_pkg::op_nop;
        end else if (instruction_latch[15:11] == `OPC_BRA) begin
            op = fetch_pkg::op_bra;
        end else if (instruction_latch[15:9] == `OPC_TEST_FILE_SKIP_IF_ZERO) begin
            op = fetch_pkg::op_test_file_skip_if_zero;
        end else if (instruction_latch[15:10] == `OPC_ADD_W_TO_FILE) begin
            op = fetch_pkg::op_add_w_to_file;
        end else if (instruction_latch[15:8] == `OPC_RETURN_WITH_LITERAL) begin
            op = fetch_pkg::op_return_with_literal;
        end else if (instruction_latch[15:8] == `OPC_MOVLW) begin
            op = fetch_pkg::op_movlw;
        end else if (instruction_latch[15:2] == `OPC_TBLRD) begin
            op = fetch_pkg::op_tblrd;
        end
    end

    assign ex_file = file_addr(instruction_latch[8], instruction_latch[7:0], bank_select);
    assign sum     = operand + working_register;

    // Destination write and branch decision, settled in phase three
    always_comb begin
        next_wr     = 1'b0;
        next_waddr  = ex_file;
        next_wdata  = sum;
        next_branch = 1'b0;
        next_target = fetch_addr;
        case (op)
            fetch_pkg::op_add_w_to_file: begin
                next_wr = instruction_latch[9];
            end
            fetch_pkg::op_second: begin
                if (pending == fetch_pkg::op_move) begin
                    next_wr    = 1'b1;
                    next_waddr = instruction_latch[11:0];
                    next_wdata = move_byte;
                end else if (pending != fetch_pkg::op_lfsr) begin
                    next_branch = 1'b1;
                    next_target = {instruction_latch[11:0], pending_low, 1'b0};
                end
            end
            fetch_pkg::op_bra: begin
                next_branch = 1'b1;
                next_target = fetch_addr + {{9{instruction_latch[10]}}, instruction_latch[10:0], 1'b0};
            end
            fetch_pkg::op_return_with_literal: begin
                next_branch = 1'b1;
                next_target = {return_addr[`PC_W-1:1], 1'b0};
            end
            default: next_wr = 1'b0;
        endcase
        if (next_wr && next_waddr == `ADDR_PC_LOW) begin
            // Low byte write redirects the counter; the data memory never sees it
            next_wr     = 1'b0;
            next_branch = 1'b1;
            next_target = {fetch_addr[`PC_W-1:8], next_wdata[7:1], 1'b0};
        end
    end

    // Program counter
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc         <= `PC_RESET;
            fetch_addr <= `PC_RESET;
        end else if (clk_en) begin
            if (phase == fetch_pkg::phase_one) begin
                fetch_addr <= pc;
                pc         <= pc + `PC_STEP;
            end else if (phase == fetch_pkg::phase_four && branch_taken) begin
                pc <= branch_target;
            end
        end
    end

    // Program memory port: table read in phase two, fetch in phase four
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prog_addr <= `PC_RESET;
            prog_rd   <= 1'b0;
        end else if (clk_en) begin
            case (phase)
                fetch_pkg::phase_one: begin
                    prog_addr <= {table_pointer[`PC_W-1:1], 1'b0};
                    prog_rd   <= (op == fetch_pkg::op_tblrd);
                end
                fetch_pkg::phase_three: begin
                    prog_addr <= fetch_addr;
                    prog_rd   <= 1'b1;
                end
                default: prog_rd <= 1'b0;
            endcase
        end
    end

    // Table pointer and latch
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            table_pointer <= `PC_RESET;
            table_latch   <= `BYTE_ZERO;
        end else if (clk_en) begin
            if (phase == fetch_pkg::phase_two && op == fetch_pkg::op_tblrd) begin
                // One byte per access, odd pointer picks the high byte
                table_latch <= table_pointer[0] ? prog_data[15:8] : prog_data[7:0];
                if (instruction_latch[0]) begin
                    table_pointer <= table_pointer + 21'h000001;
                end
            end else if (phase == fetch_pkg::phase_four && data_wr) begin
                if (data_addr == `ADDR_TBL_LOW) begin
                    table_pointer[7:0] <= data_wdata;
                end else if (data_addr == `ADDR_TBL_HIGH) begin
                    table_pointer[15:8] <= data_wdata;
                end else if (data_addr == `ADDR_TBL_UPPER) begin
                    table_pointer[20:16] <= data_wdata[4:0];
                end else if (data_addr == `ADDR_TBL_LATCH) begin
                    table_latch <= data_wdata;
                end
            end
        end
    end

    // Data memory port
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data_addr  <= {`ACCESS_LOW_BANK, `BYTE_ZERO};
            data_rd    <= 1'b0;
            data_wr    <= 1'b0;
            data_wdata <= `BYTE_ZERO;
            operand    <= `BYTE_ZERO;
            move_byte  <= `BYTE_ZERO;
        end else if (clk_en) begin
            case (phase)
                fetch_pkg::phase_one: begin
                    data_addr <= (op == fetch_pkg::op_move) ? instruction_latch[11:0] : ex_file;
                    data_rd   <= (op == fetch_pkg::op_move) || (op == fetch_pkg::op_test_file_skip_if_zero)
                                 || (op == fetch_pkg::op_add_w_to_file);
                end
                fetch_pkg::phase_two: begin
                    data_rd <= 1'b0;
                    // Counter low byte and table latch shadow the memory answer
                    if (data_addr == `ADDR_PC_LOW) begin
                        operand <= fetch_addr[7:0];
                    end else if (data_addr == `ADDR_TBL_LATCH) begin
                        operand <= table_latch;
                    end else begin
                        operand <= data_rdata;
                    end
                end
                fetch_pkg::phase_three: begin
                    if (op == fetch_pkg::op_move) begin
                        move_byte <= operand;
                    end
                    data_addr  <= next_waddr;
                    data_wdata <= next_wdata;
                    data_wr    <= next_wr;
                end
                default: data_wr <= 1'b0;
            endcase
        end
    end

    // Execute control, latch load and flush
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            instruction_latch <= `WORD_NOP;
            exec_valid        <= 1'b0;
            pending           <= fetch_pkg::op_nop;
            pending_low       <= `BYTE_ZERO;
            branch_taken      <= 1'b0;
            branch_target     <= `PC_RESET;
            skip_next         <= 1'b0;
            w_load            <= 1'b0;
            w_value           <= `BYTE_ZERO;
            working_register  <= `BYTE_ZERO;
            stack_push        <= 1'b0;
            push_addr         <= `PC_RESET;
            stack_pop         <= 1'b0;
            fsr_load          <= 1'b0;
            fsr_index         <= 2'h0;
            fsr_value         <= 12'h000;
        end else if (clk_en) begin
            case (phase)
                fetch_pkg::phase_three: begin
                    branch_taken  <= next_branch;
                    branch_target <= next_target;
                    skip_next     <= (op == fetch_pkg::op_test_file_skip_if_zero) && (operand == `BYTE_ZERO);
                    w_load        <= (op == fetch_pkg::op_add_w_to_file && !instruction_latch[9])
                                     || op == fetch_pkg::op_return_with_literal || op == fetch_pkg::op_movlw;
                    w_value       <= (op == fetch_pkg::op_add_w_to_file) ? sum : instruction_latch[7:0];
                    stack_push    <= (op == fetch_pkg::op_second) && (pending == fetch_pkg::op_call);
                    push_addr     <= fetch_addr;
                    stack_pop     <= (op == fetch_pkg::op_return_with_literal);
                    fsr_load      <= (op == fetch_pkg::op_second) && (pending == fetch_pkg::op_lfsr);
                    fsr_index     <= pending_low[5:4];
                    fsr_value     <= {pending_low[3:0], instruction_latch[7:0]};
                end
                fetch_pkg::phase_four: begin
                    if (w_load) begin
                        working_register <= w_value;
                    end
                    // Word fetched now executes next cycle while this one retires
                    instruction_latch <= prog_data;
                    exec_valid        <= !(branch_taken || skip_next);
                    case (op)
                        fetch_pkg::op_goto, fetch_pkg::op_call, fetch_pkg::op_lfsr, fetch_pkg::op_move: begin
                            pending <= op;
                        end
                        default: begin
                            pending <= fetch_pkg::op_nop;
                        end
                    endcase
                    pending_low  <= instruction_latch[7:0];
                    branch_taken <= 1'b0;
                    skip_next    <= 1'b0;
                    w_load       <= 1'b0;
                    stack_push   <= 1'b0;
                    stack_pop    <= 1'b0;
                    fsr_load     <= 1'b0;
                end
                default: branch_taken <= branch_taken;
            endcase
        end
    end

endmodule

// ==== bench/fetch_checker.sv ====
// Port assertions for the instruction fetch pipeline
`timescale 1ns/1ps
`include "fetch_defines.svh"

module fetch_checker (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                clk_en,
    input wire logic [3:0]          phase_clk,
    input wire logic [`PC_W-1:0]    pc,
    input wire logic [`PC_W-1:0]    prog_addr,
    input wire logic                prog_rd,
    input wire logic [`WORD_W-1:0]  prog_data,
    input wire logic [`DADDR_W-1:0] data_addr,
    input wire logic                data_rd,
    input wire logic                data_wr,
    input wire logic                stack_push,
    input wire logic                stack_pop,
    input wire logic                fsr_load,
    input wire logic [`PC_W-1:0]    return_addr,
    input wire logic [`WORD_W-1:0]  instruction_latch,
    input wire logic                exec_valid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_phase_rotate;
        clk_en |=> phase_clk == {$past(phase_clk[2:0]), $past(phase_clk[3])};
    endproperty
    a_phase_rotate: assert property (p_phase_rotate) else $error("phase did not rotate");

    property p_freeze;
        !clk_en |=> $stable(phase_clk) && $stable(pc) && $stable(instruction_latch);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_pc_even;
        pc[0] == 1'b0 && prog_addr[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("odd program address");

    property p_pc_step;
        (clk_en && phase_clk == `PHASE_HOT_ONE) |=> pc == $past(pc) + `PC_STEP;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc did not step by two");

    property p_pc_hold;
        (clk_en && (phase_clk == `PHASE_HOT_TWO || phase_clk == `PHASE_HOT_THREE)) |=> $stable(pc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved mid cycle");

    property p_prog_rd;
        prog_rd |-> (phase_clk == `PHASE_HOT_FOUR || phase_clk == `PHASE_HOT_TWO);
    endproperty
    a_prog_rd: assert property (p_prog_rd) else $error("program read in wrong phase");

    property p_latch_load;
        (clk_en && prog_rd && phase_clk == `PHASE_HOT_FOUR) |=> !exec_valid || instruction_latch == $past(prog_data);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("fetched word not latched");

    property p_latch_hold;
        (clk_en && phase_clk != `PHASE_HOT_FOUR) |=> $stable(instruction_latch) && $stable(exec_valid);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed mid cycle");

    property p_data_rd;
        data_rd |-> phase_clk == `PHASE_HOT_TWO;
    endproperty
    a_data_rd: assert property (p_data_rd) else $error("operand read outside phase two");

    property p_data_wr;
        data_wr |-> phase_clk == `PHASE_HOT_FOUR && data_addr != `ADDR_PC_LOW;
    endproperty
    a_data_wr: assert property (p_data_wr) else $error("bad destination write");

    property p_pop_flush;
        (clk_en && stack_pop) |=> (pc == $past(return_addr) && !exec_valid) ##1 !exec_valid [*3];
    endproperty
    a_pop_flush: assert property (p_pop_flush) else $error("return did not redirect and flush");

    property p_strobe_phase;
        (stack_push || stack_pop || fsr_load) |-> phase_clk == `PHASE_HOT_FOUR;
    endproperty
    a_strobe_phase: assert property (p_strobe_phase) else $error("stack or select strobe off phase four");

    property p_push_flush;
        (clk_en && stack_push) |=> !exec_valid ##1 !exec_valid [*3];
    endproperty
    a_push_flush: assert property (p_push_flush) else $error("call did not flush");

    c_pop: cover property (stack_pop);
    c_push: cover property (stack_push);
    c_write: cover property (data_wr);
    c_table: cover property (prog_rd && phase_clk == `PHASE_HOT_TWO);
endmodule

// ==== bench/prog_memory.sv ====
// Behavioural program memory answering the fetch port
`timescale 1ns/1ps
`include "fetch_defines.svh"

module prog_memory (
    input wire logic                clk_sys,
    input wire logic                prog_rd,
    input wire logic [`PC_W-1:0]    prog_addr,
    output logic [`WORD_W-1:0]      prog_data
);
    logic [`WORD_W-1:0] words [0:63];
    logic [`WORD_W-1:0] last;

    // Word index drops the byte bit; both bytes of a word come back together
    always_comb prog_data = prog_rd ? words[prog_addr[6:1]] : ~last;

    // Idle bus shows the inverse of the last word so stale data never matches
    always_ff @(posedge clk_sys) begin
        if (prog_rd) begin
            last <= words[prog_addr[6:1]];
        end
    end

    task automatic load(input int index, input logic [`WORD_W-1:0] value);
        words[index] = value;
    endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the instruction fetch pipeline
`timescale 1ns/1ps
`include "fetch_defines.svh"

module testbench;
    logic                clk_sys;
    logic                rst_n;
    logic                clk_en;
    logic [3:0]          phase_clk;
    logic [`PC_W-1:0]    pc;
    logic [`PC_W-1:0]    prog_addr;
    logic                prog_rd;
    logic [`WORD_W-1:0]  prog_data;
    logic [`DADDR_W-1:0] data_addr;
    logic                data_rd;
    logic [7:0]          data_rdata;
    logic                data_wr;
    logic [7:0]          data_wdata;
    logic [3:0]          bank_select;
    logic                stack_pop;
    logic                stack_push;
    logic [`PC_W-1:0]    push_addr;
    logic                fsr_load;
    logic [1:0]          fsr_index;
    logic [11:0]         fsr_value;
    logic [`PC_W-1:0]    seen_push[$];
    logic [13:0]         seen_fsr[$];
    logic [`PC_W-1:0]    return_addr;
    logic [`WORD_W-1:0]  instruction_latch;
    logic                exec_valid;
    logic [7:0]          working_register;
    logic [`PC_W-1:0]    table_pointer;
    logic [7:0]          table_latch;
    int                  bad_count;
    int                  num_checks;
    logic [15:0]         seen_words[$];
    logic [7:0]          seen_w[$];
    logic [19:0]         seen_wr[$];

    // Goto, branch onto a lone second word, return, select load, skip onto a lone second word, call,
    // computed jump, move, both table reads, branch loop
    localparam logic [15:0] IMAGE [0:26] = '{16'h0E55, 16'hEF04, 16'hF000, 16'h0E11, 16'hD001, 16'h0E22,
        16'hF456, 16'h0C77, 16'hEE12, 16'hF034, 16'h66F5, 16'hC000, 16'hF456, 16'hEC10, 16'hF000, 16'h0000,
        16'h2600, 16'h0E04, 16'h26F9, 16'h0E99, 16'h0E98, 16'h0E33, 16'hC000, 16'hFFF6, 16'h0008, 16'h0009,
        16'hD7FF};
    localparam logic [15:0] EXP_WORDS [0:15] = '{16'h0E55, 16'hEF04, 16'hD001, 16'h0C77, 16'hEE12, 16'h66F5,
        16'hEC10, 16'h2600, 16'h0E04, 16'h26F9, 16'h0E33, 16'hC000, 16'h0008, 16'h0009, 16'hD7FF, 16'hD7FF};
    localparam logic [7:0] EXP_W [0:15] = '{8'h00, 8'h55, 8'h55, 8'h55, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77,
        8'h04, 8'h04, 8'h33, 8'h33, 8'h33, 8'h33, 8'h33};

    instruction_fetch_pipeline uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .phase_clk(phase_clk), .pc(pc),
        .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data), .data_addr(data_addr),
        .data_rd(data_rd), .data_rdata(data_rdata), .data_wr(data_wr), .data_wdata(data_wdata),
        .bank_select(bank_select), .stack_push(stack_push), .push_addr(push_addr), .stack_pop(stack_pop),
        .return_addr(return_addr), .fsr_load(fsr_load), .fsr_index(fsr_index), .fsr_value(fsr_value),
        .instruction_latch(instruction_latch), .exec_valid(exec_valid), .working_register(working_register),
        .table_pointer(table_pointer), .table_latch(table_latch)
    );

    prog_memory mem (.clk_sys(clk_sys), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Pre-edge values are the settled ones of the closing cycle
    always @(posedge clk_sys) begin
        if (rst_n === 1'b1 && clk_en === 1'b1) begin
            if (exec_valid === 1'b1 && phase_clk === `PHASE_HOT_TWO && instruction_latch[15:12] !== `SECOND_TAG) begin
                seen_words.push_back(instruction_latch);
                seen_w.push_back(working_register);
            end
            if (data_wr === 1'b1) begin
                seen_wr.push_back({data_addr, data_wdata});
            end
            if (stack_push === 1'b1) begin
                seen_push.push_back(push_addr);
            end
            if (fsr_load === 1'b1) begin
                seen_fsr.push_back({fsr_index, fsr_value});
            end
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, expected, seen);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check_reset();
        check("reset phase", phase_clk, `PHASE_HOT_ONE);
        check("reset pc", pc, `PC_RESET);
        check("reset valid", exec_valid, 1'b0);
        check("reset fetch strobe", prog_rd, 1'b0);
        check("reset working register", working_register, `BYTE_ZERO);
        check("reset table pointer", table_pointer, `PC_RESET);
        check("reset table latch", table_latch, `BYTE_ZERO);
    endtask

    task automatic check_freeze();
        logic [3:0]         phase_snap;
        logic [`PC_W-1:0]   pc_snap;
        phase_snap = phase_clk;
        pc_snap = pc;
        clk_en = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("frozen phase", phase_clk, phase_snap);
        check("frozen pc", pc, pc_snap);
        clk_en = 1'b1;
    endtask

    task automatic check_program();
        int i;
        for (i = 0; i < 300 && seen_words.size() < 16; i++) begin
            @(negedge clk_sys);
        end
        check("executed count", seen_words.size(), 16);
        if (seen_words.size() < 16) begin
            stop_test();
        end
        for (i = 0; i < 16; i++) begin
            check("executed word", seen_words[i], EXP_WORDS[i]);
            check("working register", seen_w[i], EXP_W[i]);
        end
        check("write count", seen_wr.size(), 2);
        check("push count", seen_push.size(), 1);
        check("call return address", seen_push[0], 21'h00001E);
        check("select load count", seen_fsr.size(), 1);
        check("select load value", seen_fsr[0], {2'h1, 12'h234});
        check("add destination write", seen_wr[0], {12'h000, 8'h82});
        check("move destination write", seen_wr[1], {`ADDR_TBL_LOW, 8'h0B});
        check("table pointer", table_pointer, 21'h00000C);
        check("table latch odd byte", table_latch, 8'h0E);
    endtask

    initial begin
        bad_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        bank_select = 4'h0;
        data_rdata = 8'h0B;
        return_addr = 21'h000010;
        for (int k = 0; k < 27; k++) begin
            mem.load(k, IMAGE[k]);
        end
        repeat (8) @(negedge clk_sys);
        check_reset();
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        check_freeze();
        check_program();
        stop_test();
    end
endmodule

bind instruction_fetch_pipeline fetch_checker u_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .phase_clk(phase_clk), .pc(pc),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data), .data_addr(data_addr),
    .data_rd(data_rd), .data_wr(data_wr), .stack_push(stack_push), .stack_pop(stack_pop),
    .fsr_load(fsr_load), .return_addr(return_addr),
    .instruction_latch(instruction_latch), .exec_valid(exec_valid)
);
